// >>> src/lal_consts.vh
`ifndef LAL_CONSTS_VH
`define LAL_CONSTS_VH
// Indicator count per group and sources per indicator
`define LAL_NLED 8
`define LAL_NSRC 5
`define LAL_NREL 6
// Appearance codes, 3 bits
`define LAL_AP_OFF 3'h0
`define LAL_AP_RED 3'h1
`define LAL_AP_REDF 3'h2
`define LAL_AP_GRN 3'h3
`define LAL_AP_GRNF 3'h4
// Drive codes to the lamp: bit0 green, bit1 red
`define LAL_LAMP_OFF 2'h0
`define LAL_LAMP_GRN 2'h1
`define LAL_LAMP_RED 2'h2
// Blink half period: 250 ms at 100 ns clock
`define LAL_BLINK_MS 250
`define LAL_CLK_NS 100
`define LAL_BLINK_CYC ((`LAL_BLINK_MS * 1000000) / `LAL_CLK_NS)
`define LAL_BLINK_W 22
// Health states
`define LAL_H_BOOT 2'h0
`define LAL_H_OK 2'h1
`define LAL_H_FAULT 2'h2
`define LAL_H_FATAL 2'h3
`endif

// >>> src/lal_led_cell.v
`timescale 1ns/10ps
`include "lal_consts.vh"
// One configurable indicator: OR of optionally inverted sources, optional latch, appearance
module lal_led_cell
(
	input wire clk,
	input wire rstn,
	input wire [4:0] src,
	input wire [4:0] inv,
	input wire hold_en,
	input wire ack_own,
	input wire ack_all,
	input wire [2:0] act_ap,
	input wire [2:0] inact_ap,
	input wire restore_vld,
	input wire restore_lat,
	input wire [2:0] restore_ap,
	input wire blink,
	output reg [1:0] lamp_q,
	output wire latched,
	output wire [2:0] latched_ap
);
	wire cond; // Combined source condition
	reg lat_q; // Latch holds a pickup
	reg [2:0] lap_q; // Appearance captured at pickup
	reg [1:0] lamp_d;
	reg [2:0] ap;
	assign cond = |(src ^ inv); // [RL5] [RL6]
	assign latched = lat_q;
	assign latched_ap = lap_q;
	// Latch store and acknowledge
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			lat_q <= 1'b0;
			lap_q <= `LAL_AP_OFF;
		end
		else if (restore_vld)
		begin
			// Reload saved latch after supply return
			lat_q <= restore_lat; // [RL11]
			lap_q <= restore_ap;
		end
		else if (hold_en && cond)
		begin
			lat_q <= 1'b1; // [RL1]
			lap_q <= act_ap;
		end
		else if (lat_q && !cond && (ack_all || (hold_en && ack_own)))
			lat_q <= 1'b0; // [RL13] [RL14] [RL8] [RL7]
	end
	// Appearance: latch wins even if hold disabled later
	always @*
	begin
		if (lat_q)
			ap = lap_q; // [RL12]
		else if (cond)
			ap = act_ap; // [RL2] [RL3]
		else
			ap = inact_ap; // [RL4]
	end
	// Map appearance to lamp drive
	always @*
	begin
		case (ap)
			`LAL_AP_RED: lamp_d = `LAL_LAMP_RED;
			`LAL_AP_REDF: lamp_d = blink ? `LAL_LAMP_RED : `LAL_LAMP_OFF; // [RL24]
			`LAL_AP_GRN: lamp_d = `LAL_LAMP_GRN;
			`LAL_AP_GRNF: lamp_d = blink ? `LAL_LAMP_GRN : `LAL_LAMP_OFF;
			default: lamp_d = `LAL_LAMP_OFF;
		endcase
	end
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			lamp_q <= `LAL_LAMP_OFF;
		else
			lamp_q <= lamp_d;
	end
endmodule // lal_led_cell

// >>> src/lal_top.v
`timescale 1ns/10ps
`include "lal_consts.vh"
// Notes on behaviour
// RL1: Hold mode stores the alarm-set state
// RL2: Without hold, indicator follows combined alarms
// RL3: Any source true shows active appearance
// RL4: No source true shows inactive appearance
// RL5: Up to five sources ORed per indicator
// RL6: Per-source inversion before the OR
// RL7: Panel clear button acknowledges latches
// RL8: Own ack signal acknowledges in hold mode
// RL9: External ack source acknowledges all
// RL10: Host command acknowledges all indicators
// RL11: Latched appearance survives supply loss
// RL12: Latch persists across configuration change
// RL13: Only acknowledgement clears a latch
// RL14: Ack effective only after sources drop
// RL15: Health lamp flashes green during boot
// RL16: Health lamp steady green after boot
// RL17: Health lamp red on supervision fault
// RL18: Health lamp behaviour is not configurable
// RL19: Disarmed flag; supervision contact never disarmed
// RL20: Forced flag when any relay forced
// RL21: Six relay state outputs
// RL22: Group B identical, own configuration
// RL23: Configurer avoids duplicate colour meanings
// RL24: Common fixed blink period from clock
module lal_top
(
	input wire clk,
	input wire rstn,
	input wire [39:0] grp_a_src,
	input wire [39:0] grp_b_src,
	input wire [39:0] grp_a_inv,
	input wire [39:0] grp_b_inv,
	input wire [15:0] hold_en,
	input wire [15:0] ack_own,
	input wire [47:0] act_ap,
	input wire [47:0] inact_ap,
	input wire clear_button,
	input wire external_ack_unit,
	input wire host_ack,
	input wire restore_vld,
	input wire [15:0] restore_lat,
	input wire [47:0] restore_ap,
	input wire boot_done,
	input wire sup_fault,
	input wire sup_fatal,
	input wire [5:0] relay_drive,
	input wire [5:0] relay_force_en,
	input wire [5:0] relay_force_val,
	input wire disarm_req,
	input wire sup_contact_drive,
	output wire [31:0] lamp,
	output wire [15:0] latched,
	output wire [47:0] latched_ap,
	output reg [1:0] health_lamp_q,
	output reg [5:0] output_relay_state_q,
	output reg sup_contact_q,
	output reg disarmed_q,
	output reg outs_forced_q
);
	reg [2:0] btn_s1_q; // First sync stage: button, ext ack, host
	reg [2:0] btn_s2_q; // Second sync stage
	reg [2:0] btn_s3_q; // Previous value for edge detect
	reg [3:0] sup_s1_q; // Supervision inputs first stage
	reg [3:0] sup_s2_q;
	reg [`LAL_BLINK_W-1:0] blink_cnt_q; // Blink divider
	reg blink_q; // Blink phase
	reg [1:0] hstate_q; // Health state
	reg [1:0] hstate_d;
	wire ack_all; // Global acknowledge pulse
	wire [79:0] src_all; // Group B sources above group A
	wire [79:0] inv_all; // Inversion settings, same layout
	genvar g;
	assign src_all = {grp_b_src, grp_a_src};
	assign inv_all = {grp_b_inv, grp_a_inv};
	// Synchronise asynchronous acknowledge sources
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			btn_s1_q <= 3'h0;
			btn_s2_q <= 3'h0;
			btn_s3_q <= 3'h0;
			sup_s1_q <= 4'h0;
			sup_s2_q <= 4'h0;
		end
		else
		begin
			btn_s1_q <= {host_ack, external_ack_unit, clear_button};
			btn_s2_q <= btn_s1_q;
			btn_s3_q <= btn_s2_q;
			sup_s1_q <= {disarm_req, sup_fatal, sup_fault, boot_done};
			sup_s2_q <= sup_s1_q;
		end
	end
	// Rising edge of any global source acknowledges everything
	assign ack_all = |(btn_s2_q & ~btn_s3_q); // [RL7] [RL9] [RL10]
	// Common blink timebase
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			blink_cnt_q <= {`LAL_BLINK_W{1'b0}};
			blink_q <= 1'b0;
		end
		else if (blink_cnt_q == `LAL_BLINK_CYC - 1)
		begin
			blink_cnt_q <= {`LAL_BLINK_W{1'b0}};
			blink_q <= ~blink_q; // [RL24]
		end
		else
			blink_cnt_q <= blink_cnt_q + {{(`LAL_BLINK_W-1){1'b0}}, 1'b1};
	end
	// Both groups from one cell per indicator, own config slices
	generate
		for (g = 0; g < 2 * `LAL_NLED; g = g + 1)
		begin : g_led
			lal_led_cell u_cell
			(
				.clk(clk),
				.rstn(rstn),
				.src(src_all[g*`LAL_NSRC +: `LAL_NSRC]),
				.inv(inv_all[g*`LAL_NSRC +: `LAL_NSRC]),
				.hold_en(hold_en[g]),
				.ack_own(ack_own[g]),
				.ack_all(ack_all),
				.act_ap(act_ap[g*3 +: 3]),
				.inact_ap(inact_ap[g*3 +: 3]),
				.restore_vld(restore_vld),
				.restore_lat(restore_lat[g]),
				.restore_ap(restore_ap[g*3 +: 3]),
				.blink(blink_q),
				.lamp_q(lamp[g*2 +: 2]),
				.latched(latched[g]),
				.latched_ap(latched_ap[g*3 +: 3])
			); // [RL22]
		end
	endgenerate
	// Health state: fixed, no configuration input
	always @*
	begin
		hstate_d = hstate_q;
		case (hstate_q)
			`LAL_H_BOOT:
			begin
				if (sup_s2_q[2])
					hstate_d = `LAL_H_FATAL; // [RL17]
				else if (sup_s2_q[1])
					hstate_d = `LAL_H_FAULT;
				else if (sup_s2_q[0])
					hstate_d = `LAL_H_OK; // [RL16]
			end
			`LAL_H_OK:
			begin
				if (sup_s2_q[2])
					hstate_d = `LAL_H_FATAL;
				else if (sup_s2_q[1])
					hstate_d = `LAL_H_FAULT;
			end
			`LAL_H_FAULT:
			begin
				if (sup_s2_q[2])
					hstate_d = `LAL_H_FATAL;
			end
			default: hstate_d = `LAL_H_FATAL;
		endcase
	end
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			hstate_q <= `LAL_H_BOOT;
			health_lamp_q <= `LAL_LAMP_OFF;
		end
		else
		begin
			hstate_q <= hstate_d;
			case (hstate_q)
				`LAL_H_BOOT: health_lamp_q <= blink_q ? `LAL_LAMP_GRN : `LAL_LAMP_OFF; // [RL15]
				`LAL_H_OK: health_lamp_q <= `LAL_LAMP_GRN; // [RL16] [RL18]
				`LAL_H_FAULT: health_lamp_q <= blink_q ? `LAL_LAMP_RED : `LAL_LAMP_OFF; // [RL17]
				default: health_lamp_q <= `LAL_LAMP_RED;
			endcase
		end
	end
	// Relay status, disarm and force flags
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			output_relay_state_q <= 6'h00;
			sup_contact_q <= 1'b0;
			disarmed_q <= 1'b0;
			outs_forced_q <= 1'b0;
		end
		else
		begin
			output_relay_state_q <= sup_s2_q[3] ? 6'h00 :
				((relay_drive & ~relay_force_en) | (relay_force_val & relay_force_en)); // [RL21]
			sup_contact_q <= sup_contact_drive; // [RL19]
			disarmed_q <= sup_s2_q[3]; // [RL19]
			outs_forced_q <= |relay_force_en; // [RL20]
		end
	end
endmodule // lal_top

// >>> verif/lal_ack_model.sv
`timescale 1ns/10ps
// Panel button, external input and host acknowledge sources
module lal_ack_model
(
	input wire clk,
	input wire go,
	input wire [1:0] sel,
	output wire clear_button,
	output wire external_ack_unit,
	output wire host_ack
);
	reg [1:0] n_q = 2'h0; // Pulse cycles left
	// Chosen line high two cycles
	always @(posedge clk)
		n_q <= go ? 2'h2 : n_q - {1'b0, n_q != 2'h0};
	assign clear_button = n_q != 2'h0 && sel == 2'h0; // Panel press
	assign external_ack_unit = n_q != 2'h0 && sel == 2'h1; // Input rise
	assign host_ack = n_q != 2'h0 && sel == 2'h2; // Link command
endmodule // lal_ack_model

// >>> verif/lal_top_properties.sv
`timescale 1ns/10ps
// Watches indicator 0, flags and health lamp
module lal_top_properties
(
	input wire clk,
	input wire rstn,
	input wire [39:0] grp_a_src,
	input wire [39:0] grp_a_inv,
	input wire [15:0] hold_en,
	input wire [47:0] act_ap,
	input wire boot_done,
	input wire sup_fault,
	input wire sup_fatal,
	input wire [5:0] relay_force_en,
	input wire disarm_req,
	input wire [31:0] lamp,
	input wire [15:0] latched,
	input wire [1:0] health_lamp_q,
	input wire disarmed_q,
	input wire outs_forced_q
);
	wire c0 = |(grp_a_src[4:0] ^ grp_a_inv[4:0]); // Indicator 0 condition
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	sequence boot_wait;
		!boot_done [*4];
	endsequence
	sequence boot_good;
		(boot_done && !sup_fault && !sup_fatal) [*4];
	endsequence
	latch_set_a: assert property (hold_en[0] && c0 |=> latched[0])
		else $error("no latch");
	ack_blocked_a: assert property (latched[0] && c0 |=> latched[0])
		else $error("early clear");
	follow_red_a: assert property (!hold_en[0] && !latched[0] && c0
		&& act_ap[2:0] == 3'h1 |=> lamp[1:0] == 2'h2) else $error("not red");
	disarm_a: assert property (disarm_req [*4] |-> disarmed_q)
		else $error("not disarmed");
	forced_a: assert property (|relay_force_en |=> outs_forced_q)
		else $error("no forced flag");
	health_boot_a: assert property (boot_wait |-> !health_lamp_q[1])
		else $error("boot red");
	health_ok_a: assert property (boot_good |=> health_lamp_q == 2'h1)
		else $error("not green");
	health_red_a: assert property (sup_fatal [*4] |=> health_lamp_q == 2'h2)
		else $error("not red");
endmodule // lal_top_properties
bind lal_top lal_top_properties chk_u (.*);

// >>> verif/lal_top_tb.sv
`timescale 1ns/10ps
// Drives the block, notes expectations, checks outputs
module lal_top_tb;
	reg clk = 1'b0;
	reg rstn = 1'b0;
	reg [39:0] sa = 40'h0, sb = 40'h0, ia = 40'h0, ib = 40'h0;
	reg [47:0] aap = 48'h249249249249, iap = 48'h6db6db6db6db; // Red active, green idle
	reg [15:0] hold = 16'h0, own = 16'h0, rlat = 16'h0;
	reg [47:0] rap = 48'h0;
	reg rvld = 1'b0, bd = 1'b0, ftl = 1'b0, flt = 1'b0, dis = 1'b0, scd = 1'b0, go = 1'b0;
	reg [5:0] drv = 6'h0, fen = 6'h0, fv = 6'h0;
	reg [1:0] sel = 2'h0;
	reg [95:0] r;
	reg [9:0] e;
	reg [9:0] q[$]; // Kind and expected value
	wire cb, ea, ha, dq, fq, sc;
	wire [47:0] lap; // Stored appearances
	wire [31:0] lamp;
	wire [15:0] lat;
	wire [1:0] hl;
	wire [5:0] rs;
	integer bad_count = 0, checks = 0, k;
	lal_top dut_u (.clk(clk), .rstn(rstn), .grp_a_src(sa), .grp_b_src(sb), .grp_a_inv(ia),
		.grp_b_inv(ib), .hold_en(hold), .ack_own(own), .act_ap(aap),
		.inact_ap(iap), .clear_button(cb), .external_ack_unit(ea), .host_ack(ha),
		.restore_vld(rvld), .restore_lat(rlat), .restore_ap(rap), .boot_done(bd),
		.sup_fault(flt), .sup_fatal(ftl), .relay_drive(drv), .relay_force_en(fen),
		.relay_force_val(fv), .disarm_req(dis), .sup_contact_drive(scd), .lamp(lamp),
		.latched(lat), .latched_ap(lap), .health_lamp_q(hl), .output_relay_state_q(rs),
		.sup_contact_q(sc), .disarmed_q(dq), .outs_forced_q(fq));
	lal_ack_model ack_u (.clk(clk), .go(go), .sel(sel), .clear_button(cb),
		.external_ack_unit(ea), .host_ack(ha));
	initial forever #50 clk = ~clk;
	// Hang guard
	initial
	begin
		#300000;
		bad_count = bad_count + 1;
		tally_and_finish;
	end
	task cmp(input [7:0] g, input [7:0] x);
	begin
		checks = checks + 1;
		if (g !== x)
		begin
			bad_count = bad_count + 1;
			$display("ERROR t=%0t got %h exp %h", $time, g, x);
		end
	end
	endtask
	// Lamp codes of indicators 0 and 8
	task cmp_lamp(input [7:0] x);
		cmp({4'h0, lamp[17:16], lamp[1:0]}, x);
	endtask
	// Relay states, forced and disarmed flags
	task cmp_relay(input [7:0] x);
		cmp({dq, fq, rs}, x);
	endtask
	// Latch flags, supervision contact, health lamp
	task cmp_health(input [7:0] x);
		cmp({lat[8], lat[0], 3'h0, sc, hl}, x);
	endtask
	// Stored appearances of indicators 0 and 8
	task cmp_store(input [7:0] x);
		cmp({1'b0, lap[26:24], 1'b0, lap[2:0]}, x);
	endtask
	// Every queued note, oldest first, against settled outputs
	initial forever
	begin
		@(posedge clk);
		#1;
		while (q.size() > 0)
		begin
			e = q.pop_front();
			case (e[9:8])
				2'h0: cmp_lamp(e[7:0]);
				2'h1: cmp_relay(e[7:0]);
				2'h2: cmp_health(e[7:0]);
				default: cmp_store(e[7:0]);
			endcase
		end
	end
	task note(input [1:0] kd, input [7:0] v);
		q.push_back({kd, v});
	endtask
	// Indicator 0 of both groups; other sources and group A inversions random
	task drive(input [4:0] s, input [4:0] i);
	begin
		@(posedge clk);
		r = {$urandom, $urandom, $urandom};
		sa <= {r[34:0], s};
		sb <= {r[69:35], s};
		ia <= {r[95:61], i};
		ib <= {35'h0, i};
		repeat (2) @(posedge clk);
	end
	endtask
	// Acknowledge: 0 panel, 1 input, 2 host, 3 own
	task ack(input [1:0] s);
	begin
		@(posedge clk);
		sel <= s;
		go <= 1'b1;
		own <= {7'h0, s == 2'h3, 7'h0, s == 2'h3};
		@(posedge clk);
		go <= 1'b0;
		repeat (6) @(posedge clk);
		own <= 16'h0;
	end
	endtask
	task tally_and_finish;
	begin
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask
	initial
	begin
		k = $urandom(22284);
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (6) @(posedge clk);
		bd <= 1'b1;
		for (k = 0; k < 5; k = k + 1)
		begin
			drive(5'h1 << k, 5'h0);
			note(0, 8'h0a);
			drive(5'h1 << k, 5'h1 << k);
			note(0, 8'h05);
			drive(5'h0, 5'h1 << k);
			note(0, 8'h0a);
		end
		note(2, 8'h01);
		$display("follow done");
		hold <= 16'h0101;
		for (k = 0; k < 4; k = k + 1)
		begin
			drive(5'h4, 5'h0);
			drive(5'h0, 5'h0);
			note(2, 8'hc1);
			note(0, 8'h0a);
			note(3, 8'h11);
			drive(5'h4, 5'h0);
			ack(k[1:0]);
			note(0, 8'h0a);
			drive(5'h0, 5'h0);
			ack(k[1:0]);
			note(0, 8'h05);
		end
		drive(5'h1, 5'h0);
		hold <= 16'h0;
		aap <= 48'h6db6db6db6db;
		drive(5'h0, 5'h0);
		note(0, 8'h0a);
		ack(2'h0);
		note(0, 8'h05);
		aap <= 48'h249249249249;
		rlat <= 16'h0101;
		rap <= 48'h000002000002;
		rvld <= 1'b1;
		drive(5'h0, 5'h0);
		rvld <= 1'b0;
		drive(5'h0, 5'h0);
		note(0, 8'h00);
		note(3, 8'h22);
		ack(2'h2);
		note(0, 8'h05);
		$display("latch done");
		for (k = 0; k < 6; k = k + 1)
		begin
			r = {$urandom, $urandom, $urandom};
			drv <= r[5:0];
			fen <= k == 0 ? 6'h0 : r[11:6];
			fv <= r[17:12];
			scd <= r[18];
			repeat (2) @(posedge clk);
			note(1, {1'b0, |fen, (fen & fv) | (~fen & drv)});
			note(2, {5'h0, scd, 2'h1});
		end
		dis <= 1'b1;
		scd <= 1'b1;
		repeat (6) @(posedge clk);
		note(1, {1'b1, |fen, 6'h0});
		note(2, 8'h05);
		dis <= 1'b0;
		flt <= 1'b1;
		repeat (6) @(posedge clk);
		note(2, 8'h04);
		ftl <= 1'b1;
		repeat (6) @(posedge clk);
		note(2, 8'h06);
		repeat (2) @(posedge clk);
		$display("relay and health done");
		tally_and_finish;
	end
endmodule // lal_top_tb
